//--- logic/ddr2_pre_pkg.sv
package ddr2_pre_pkg;
  // ****************************************************
  // Bank and command geometry
  // ****************************************************
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  localparam int A10_POS = 10;
  localparam int CNT_W = 8;
  // ****************************************************
  // Clock and analog timing
  // ****************************************************
  localparam int CLK_PERIOD_PS = 20000;
  localparam int T_RAS_PS = 45000;
  localparam int T_RTP_PS = 7500;
  localparam int T_WR_PS = 15000;
  localparam int T_RP_PS = 15000;
  localparam int T_RC_PS = 60000;
  // Least times round up to whole cycles.
  localparam int RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RTP_CYC = (T_RTP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_CYC = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RC_CYC = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RP_ALL_EXTRA = 1;
  localparam int PREFETCH_GAP = 2;
  localparam int BL8_PREFETCH_OFS = 2;
  // ****************************************************
  // Mode fields and burst lengths
  // ****************************************************
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [3:0] BL4 = 4'h4;
  localparam logic [3:0] BL8 = 4'h8;
  localparam logic [3:0] LAT_MIN_WL = 4'h1;
  // ****************************************************
  // Command codes {ras_n, cas_n, we_n}
  // ****************************************************
  typedef enum logic [2:0] {
    CMD_ACT = 3'h3,
    CMD_RD = 3'h5,
    CMD_WR = 3'h4,
    CMD_PRE = 3'h2,
    CMD_NOP = 3'h7
  } cmd_e;

  typedef logic [CNT_W-1:0] cnt_t;

  function automatic cnt_t max_cnt(input cnt_t a, input cnt_t b);
    return (a > b) ? a : b;
  endfunction
endpackage

//--- logic/ddr2_cmd_if.sv
`timescale 1ns/1ns
interface ddr2_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] bank_addr;
  logic [13:0] addr;
  logic [7:0] bank_open;
  logic busy;

  modport ctrl (
    output cs_n, ras_n, cas_n, we_n, bank_addr, addr,
    input bank_open, busy
  );
  modport dev (
    input cs_n, ras_n, cas_n, we_n, bank_addr, addr,
    output bank_open, busy
  );
endinterface

//--- logic/ddr2_pre_dev.sv
`timescale 1ns/1ns
module ddr2_pre_dev
  import ddr2_pre_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Command bus
  ddr2_cmd_if.dev CMD,
  // Latency and mode settings
  input wire logic [3:0] AL_I,
  input wire logic [3:0] CL_I,
  input wire logic [2:0] BL_CODE_I,
  // Per-bank status
  output logic [NUM_BANKS-1:0] BANK_OPEN_O,
  output logic [NUM_BANKS-1:0] BANK_PRECHARGING_O
);
  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS-1:0] pend;
    logic [NUM_BANKS-1:0][CNT_W-1:0] ras_cnt;
    logic [NUM_BANKS-1:0][CNT_W-1:0] ap_cnt;
    logic [NUM_BANKS-1:0][CNT_W-1:0] rp_cnt;
    logic [NUM_BANKS-1:0] prech;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic sel;
  cmd_e cmd;
  cnt_t bl_half;
  cnt_t wl;
  cnt_t rd_ap_dly;
  cnt_t wr_ap_dly;

  assign sel = !CMD.cs_n;
  assign cmd = cmd_e'({CMD.ras_n, CMD.cas_n, CMD.we_n});
  // Burst length code other than 8 is treated as 4.
  assign bl_half = (BL_CODE_I == BL_CODE_8) ? cnt_t'(BL8 >> 1) :
    cnt_t'(BL4 >> 1);
  assign wl = cnt_t'(AL_I) + cnt_t'(CL_I) - cnt_t'(LAT_MIN_WL);
  // Last prefetch plus two clocks, and at least tRTP from it.
  assign rd_ap_dly = cnt_t'(AL_I) +
    ((BL_CODE_I == BL_CODE_8) ? cnt_t'(BL8_PREFETCH_OFS) : cnt_t'(0)) +
    max_cnt(cnt_t'(RTP_CYC), cnt_t'(PREFETCH_GAP));
  assign wr_ap_dly = wl + bl_half + cnt_t'(WR_CYC);

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    next_cur = cur;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (cur.ras_cnt[b] != '0) begin
        next_cur.ras_cnt[b] = cur.ras_cnt[b] - cnt_t'(1);
      end
      if (cur.rp_cnt[b] != '0) begin
        next_cur.rp_cnt[b] = cur.rp_cnt[b] - cnt_t'(1);
      end else begin
        next_cur.prech[b] = 1'b0;
      end
      if (cur.pend[b]) begin
        if (cur.ap_cnt[b] != '0) begin
          next_cur.ap_cnt[b] = cur.ap_cnt[b] - cnt_t'(1);
        end else if (cur.ras_cnt[b] == '0) begin
          next_cur.pend[b] = 1'b0;
          next_cur.open[b] = 1'b0;
          next_cur.prech[b] = 1'b1;
          next_cur.rp_cnt[b] = cnt_t'(RP_CYC);
        end
      end
    end
    if (sel) begin
      case (cmd)
        CMD_ACT: begin
          next_cur.open[CMD.bank_addr] = 1'b1;
          next_cur.ras_cnt[CMD.bank_addr] = cnt_t'(RAS_CYC);
        end
        CMD_RD, CMD_WR: begin
          if (CMD.addr[A10_POS]) begin
            next_cur.pend[CMD.bank_addr] = 1'b1;
            next_cur.ap_cnt[CMD.bank_addr] = (cmd == CMD_RD) ?
              max_cnt(rd_ap_dly, cnt_t'(AL_I) + bl_half) : wr_ap_dly;
          end
        end
        CMD_PRE: begin
          for (int b = 0; b < NUM_BANKS; b++) begin
            if (CMD.addr[A10_POS] || (CMD.bank_addr == BANK_W'(b))) begin
              next_cur.open[b] = 1'b0;
              next_cur.pend[b] = 1'b0;
              next_cur.prech[b] = 1'b1;
              next_cur.rp_cnt[b] = CMD.addr[A10_POS] ?
                cnt_t'(RP_CYC + RP_ALL_EXTRA) : cnt_t'(RP_CYC);
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign BANK_OPEN_O = cur.open;
  assign BANK_PRECHARGING_O = cur.prech;
  assign CMD.bank_open = cur.open;
  assign CMD.busy = |cur.prech;
endmodule

//--- logic/ddr2_pre_ctrl.sv
`timescale 1ns/1ns
module ddr2_pre_ctrl
  import ddr2_pre_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // User request
  input wire logic REQ_I,
  input wire logic [2:0] REQ_CMD_I,
  input wire logic [2:0] REQ_BANK_I,
  input wire logic REQ_AUTO_CLOSE_I,
  input wire logic [3:0] AL_I,
  input wire logic [3:0] CL_I,
  input wire logic BL8_I,
  output logic ACCEPT_O,
  // Command bus
  ddr2_cmd_if.ctrl CMD
);
  // ****************************************************
  // Per-bank earliest times, precharge gap, bus and accept
  // ****************************************************
  typedef struct packed {
    logic [NUM_BANKS-1:0][CNT_W-1:0] pre_wait;
    logic [NUM_BANKS-1:0][CNT_W-1:0] act_wait;
    logic pre_gap;
    logic [5:0] bus;
    logic accept;
  } state_s;

  state_s cur;
  state_s next_cur;
  cnt_t bl_half;
  cnt_t rd_pre;
  cnt_t wr_pre;
  logic ok;
  logic all;

  assign bl_half = BL8_I ? cnt_t'(BL8 >> 1) : cnt_t'(BL4 >> 1);
  // Read spacing AL+BL/2+max(RTP,2)-2 with RTP rounded up.
  assign rd_pre = cnt_t'(AL_I) + bl_half +
    max_cnt(cnt_t'(RTP_CYC), cnt_t'(PREFETCH_GAP)) -
    cnt_t'(PREFETCH_GAP);
  assign wr_pre = cnt_t'(AL_I) + cnt_t'(CL_I) - cnt_t'(LAT_MIN_WL) +
    bl_half + cnt_t'(WR_CYC);
  assign all = REQ_AUTO_CLOSE_I && (REQ_CMD_I == CMD_PRE);

  always_comb begin
    ok = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if ((REQ_CMD_I == CMD_PRE) && (all || REQ_BANK_I == BANK_W'(b)) &&
          cur.pre_wait[b] > cnt_t'(0)) begin
        ok = 1'b0;
      end
    end
    if ((REQ_CMD_I == CMD_ACT) && cur.act_wait[REQ_BANK_I] > cnt_t'(0)) begin
      ok = 1'b0;
    end
    if ((REQ_CMD_I == CMD_PRE) && cur.pre_gap) begin
      ok = 1'b0;
    end
    // The requester sees the accept one cycle late and still holds REQ_I.
    // That leftover cycle belongs to the request already taken.
    if (cur.accept) begin
      ok = 1'b0;
    end
  end

  always_comb begin
    next_cur = cur;
    next_cur.pre_gap = 1'b0;
    next_cur.accept = 1'b0;
    next_cur.bus = {1'b1, CMD_NOP, 2'h0};
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (cur.pre_wait[b] != '0) begin
        next_cur.pre_wait[b] = cur.pre_wait[b] - cnt_t'(1);
      end
      if (cur.act_wait[b] != '0) begin
        next_cur.act_wait[b] = cur.act_wait[b] - cnt_t'(1);
      end
    end
    if (REQ_I && ok) begin
      next_cur.accept = 1'b1;
      next_cur.bus = {1'b0, REQ_CMD_I, 2'h0};
      case (REQ_CMD_I)
        CMD_ACT: begin
          next_cur.pre_wait[REQ_BANK_I] = cnt_t'(RAS_CYC);
          next_cur.act_wait[REQ_BANK_I] = cnt_t'(RC_CYC);
        end
        CMD_RD: begin
          next_cur.pre_wait[REQ_BANK_I] =
            max_cnt(cur.pre_wait[REQ_BANK_I], rd_pre);
          if (REQ_AUTO_CLOSE_I) begin
            next_cur.act_wait[REQ_BANK_I] = max_cnt(cur.act_wait[REQ_BANK_I],
              cnt_t'(AL_I) + (BL8_I ? cnt_t'(BL8_PREFETCH_OFS) : cnt_t'(0)) +
              cnt_t'(RTP_CYC + RP_CYC + RAS_CYC));
          end
        end
        CMD_WR: begin
          next_cur.pre_wait[REQ_BANK_I] =
            max_cnt(cur.pre_wait[REQ_BANK_I], wr_pre);
          if (REQ_AUTO_CLOSE_I) begin
            next_cur.act_wait[REQ_BANK_I] = max_cnt(cur.act_wait[REQ_BANK_I],
              wr_pre + cnt_t'(RP_CYC + RAS_CYC));
          end
        end
        CMD_PRE: begin
          next_cur.pre_gap = 1'b1;
          for (int b = 0; b < NUM_BANKS; b++) begin
            if (all || REQ_BANK_I == BANK_W'(b)) begin
              next_cur.act_wait[b] = max_cnt(cur.act_wait[b], all ?
                cnt_t'(RP_CYC + RP_ALL_EXTRA) : cnt_t'(RP_CYC));
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cur <= '0;
      cur.bus <= {1'b1, CMD_NOP, 2'h0};
    end else begin
      cur <= next_cur;
    end
  end

  logic [BANK_W-1:0] bank_q;
  logic a10_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bank_q <= '0;
      a10_q <= 1'b0;
    end else begin
      bank_q <= REQ_BANK_I;
      a10_q <= REQ_I && ok && REQ_AUTO_CLOSE_I;
    end
  end

  assign ACCEPT_O = cur.accept;
  assign CMD.cs_n = cur.bus[5];
  assign CMD.ras_n = cur.bus[4];
  assign CMD.cas_n = cur.bus[3];
  assign CMD.we_n = cur.bus[2];
  assign CMD.bank_addr = bank_q;
  assign CMD.addr = ROW_W'(a10_q) << A10_POS;
endmodule

//--- tb/ddr2_pre_asserts.sv
`timescale 1ns/1ns
module ddr2_pre_asserts
  import ddr2_pre_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Command bus
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bank_addr,
  input wire logic [13:0] addr,
  input wire logic [7:0] bank_open,
  input wire logic busy
);
  logic act, rd, wr, pre, all, hit;
  logic [2:0] last_b;
  assign act = !cs_n && {ras_n, cas_n, we_n} == CMD_ACT;
  assign rd = !cs_n && {ras_n, cas_n, we_n} == CMD_RD;
  assign wr = !cs_n && {ras_n, cas_n, we_n} == CMD_WR;
  assign pre = !cs_n && {ras_n, cas_n, we_n} == CMD_PRE;
  assign all = addr[A10_POS];
  // A later command to another bank weakens the check, and trips it if that bank is then precharged inside the window.
  assign hit = pre && (all || bank_addr == last_b);
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I)
      last_b <= 3'h0;
    else if (!cs_n)
      last_b <= bank_addr;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_pre_one_bank: assert property (
    pre && !all |=> !bank_open[$past(bank_addr)])
    else $error("bank still open after precharge");
  a_pre_all_banks: assert property (
    pre && all |=> bank_open == 8'h0)
    else $error("banks open after precharge all");
  a_act_opens: assert property (
    act |=> bank_open[$past(bank_addr)])
    else $error("bank closed after activate");
  a_pre_gap: assert property (
    pre |=> !pre)
    else $error("precharges back to back");
  a_rd_pre_gap: assert property (
    rd |=> !hit)
    else $error("precharge too soon after read");
  a_wr_pre_gap: assert property (
    wr |=> !hit [*3])
    else $error("precharge too soon after write");
  a_ras_min: assert property (
    act |=> !hit [*2])
    else $error("precharge before row active time");
  a_rp_all_min: assert property (
    pre && all |=> !act)
    else $error("activate too soon after precharge all");
endmodule

//--- tb/ddr2_precharge_timing_bench.sv
`timescale 1ns/1ns
module ddr2_precharge_timing_bench
  import ddr2_pre_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, ac = 1'b0, bl8 = 1'b0, w;
  logic [2:0] cmd = 3'h7, bank = 3'h0, b1;
  logic [3:0] al = 4'h0, cl = 4'h3;
  logic accept;
  logic [7:0] open_m, prech;
  int failures = 0, checked = 0, cyc = 0, t_acc, t0, t1, n;
  ddr2_cmd_if bus ();
  ddr2_pre_ctrl u_ddr2_pre_ctrl (.CLK_I(clk), .RST_I(rst), .REQ_I(req),
    .REQ_CMD_I(cmd), .REQ_BANK_I(bank), .REQ_AUTO_CLOSE_I(ac), .AL_I(al),
    .CL_I(cl), .BL8_I(bl8), .ACCEPT_O(accept), .CMD(bus.ctrl));
  ddr2_pre_dev u_ddr2_pre_dev (.CLK_I(clk), .RST_I(rst), .CMD(bus.dev),
    .AL_I(al), .CL_I(cl), .BL_CODE_I(bl8 ? BL_CODE_8 : BL_CODE_4),
    .BANK_OPEN_O(open_m), .BANK_PRECHARGING_O(prech));
  ddr2_pre_asserts u_ddr2_pre_asserts (.CLK_I(clk), .RST_I(rst),
    .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
    .bank_addr(bus.bank_addr), .addr(bus.addr), .bank_open(bus.bank_open),
    .busy(bus.busy));
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // ****************************************************
  // Expectations and checks
  // ****************************************************
  // Least spacing after a read or write, also the earliest auto close.
  function automatic int least(logic wr, int a, int c, logic b8);
    int h;
    h = b8 ? 4 : 2;
    if (wr)
      return a + c - 1 + h + WR_CYC;
    return a + h + ((RTP_CYC > 2) ? RTP_CYC : 2) - 2;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic gap(input int got, input int lo);
    checked++;
    if (got < lo) begin
      failures++;
      $display("wrong value at %0t: spacing %0d under %0d", $time, got, lo);
    end
  endtask
  task automatic issue(input cmd_e c, input logic [2:0] b, input logic a);
    @(posedge clk);
    req <= 1'b1;
    cmd <= c;
    bank <= b;
    ac <= a;
    for (n = 0; n < 80; n++) begin
      @(posedge clk);
      if (accept === 1'b1)
        break;
    end
    if (n == 80)
      gap(0, 1);
    t_acc = cyc;
    req <= 1'b0;
  endtask
  task automatic results();
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    gap(0, 1);
    results();
  end
  initial begin
    void'($urandom(32'h8c5fb9ac));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(open_m | prech, 8'h0);
    for (int b = 0; b < 8; b++)
      issue(CMD_ACT, 3'(b), 1'b0);
    repeat (2) @(posedge clk);
    chk(open_m, 8'hff);
    b1 = 3'($urandom % 8);
    issue(CMD_PRE, b1, 1'b0);
    t0 = t_acc;
    issue(CMD_PRE, b1 ^ 3'h1, 1'b0);
    gap(t_acc - t0, 2);
    repeat (2) @(posedge clk);
    chk(open_m, ~((8'h1 << b1) | (8'h1 << (b1 ^ 3'h1))));
    chk(prech, 8'h1 << (b1 ^ 3'h1));
    issue(CMD_PRE, b1, 1'b1);
    repeat (2) @(posedge clk);
    chk(open_m, 8'h0);
    t0 = t_acc;
    for (int k = 0; k < 12; k++) begin
      al <= 4'($urandom % 4);
      cl <= 4'(3 + $urandom % 3);
      bl8 <= 1'($urandom % 2);
      b1 = 3'($urandom % 8);
      w = 1'(k % 2);
      issue(CMD_ACT, b1, 1'b0);
      if (k == 0)
        gap(t_acc - t0, RP_CYC + RP_ALL_EXTRA);
      t0 = t_acc;
      issue(w ? CMD_WR : CMD_RD, b1, 1'b0);
      t1 = t_acc;
      repeat (16) @(posedge clk);
      chk({7'h0, open_m[b1]}, 8'h1);
      issue(CMD_PRE, b1, 1'b0);
      gap(t_acc - t0, RAS_CYC);
      gap(t_acc - t1, least(w, int'(al), int'(cl), bl8));
      issue(CMD_ACT, b1, 1'b0);
      issue(w ? CMD_WR : CMD_RD, b1, 1'b1);
      t1 = t_acc;
      for (n = 0; n < 80 && open_m[b1] !== 1'b0; n++)
        @(posedge clk);
      gap(cyc - t1, least(w, int'(al), int'(cl), bl8));
      chk(open_m, 8'h0);
    end
    results();
  end
endmodule
